// file: rtl/lirq_regs.svh
// offsets, field positions, reset values and timing for the link interrupt register bank
`ifndef LIRQ_REGS_SVH
`define LIRQ_REGS_SVH
`define LIRQ_OFF_MASK        8'hbb
`define LIRQ_OFF_FLAGS       8'hbc
`define LIRQ_OFF_PAUSE       8'hbd
`define LIRQ_OFF_FIBER       8'hc0
`define LIRQ_OFF_REG         8'hc1
`define LIRQ_OFF_VID         8'hc2
`define LIRQ_RST_BYTE        8'h00
`define LIRQ_FLG_P12         7
`define LIRQ_FLG_P3          2
`define LIRQ_FLG_P2          1
`define LIRQ_FLG_P1          0
`define LIRQ_FLG_W1C_MASK    8'h87
`define LIRQ_FIBER_MASK      8'hc0
`define LIRQ_REG_DIS_BIT     6
`define LIRQ_VID_MASK        8'h3f
`define LIRQ_PAUSE_LIMIT_MS  160
`define LIRQ_CLK_KHZ         50000
`define LIRQ_PAUSE_LIMIT_CYC (`LIRQ_PAUSE_LIMIT_MS * `LIRQ_CLK_KHZ)
`endif

// file: rtl/lirq_pkg.sv
// types for the link interrupt register bank
package lirq_pkg;
  typedef enum logic [2:0] {
    LIRQ_P_IDLE  = 3'b001,
    LIRQ_P_COUNT = 3'b010,
    LIRQ_P_REQ   = 3'b100
  } lirq_pause_st_t;
endpackage : lirq_pkg

// file: rtl/lirq_sync_edge.sv
// two-flop synchronisers with change detection, one per link input
`timescale 1ns/1ps
module lirq_sync_edge #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] change_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] last_r;
  logic [WIDTH-1:0] change_r;
  logic [2:0]       arm_r;

  // no change reported until last_r holds a synced level, so a link already up at reset is no event
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      arm_r <= 3'h0;
    end else begin
      arm_r <= {arm_r[1:0], 1'b1};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          meta_r[gi]   <= 1'b0;
          sync_r[gi]   <= 1'b0;
          last_r[gi]   <= 1'b0;
          change_r[gi] <= 1'b0;
        end else begin
          meta_r[gi]   <= level_in[gi];
          sync_r[gi]   <= meta_r[gi];
          last_r[gi]   <= sync_r[gi];
          change_r[gi] <= arm_r[2] & (sync_r[gi] ^ last_r[gi]);
        end
      end
    end
  endgenerate

  assign change_out = change_r;
endmodule : lirq_sync_edge

// file: rtl/lirq_bank.sv
// link change flags, interrupt mask, pause limit, fiber, regulator and vid insertion registers
`timescale 1ns/1ps
`include "lirq_regs.svh"

module lirq_bank
  import lirq_pkg::*;
#(
  parameter int PAUSE_LIMIT_CYC = `LIRQ_PAUSE_LIMIT_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       p1_analog_link,
  input  wire logic       p2_analog_link,
  input  wire logic       p1_mii_link,
  input  wire logic       p3_mii_link,
  output logic            irq_out_pin_n,
  input  wire logic       pause_active,
  output logic            pause_off_req,
  output logic [1:0]      fiber_thr_high,
  output logic            regulator_disable,
  input  wire logic       frm_valid,
  input  wire logic [1:0] frm_src_port,
  input  wire logic [1:0] frm_egress_port,
  input  wire logic       frm_untagged,
  input  wire logic       frm_tag_other,
  output logic            frm_insert_vid
);
  // ***************************************************
  // link change detection
  // ***************************************************
  logic [3:0] chg;  // 0 p1 analog, 1 p2 analog, 2 p1 mii, 3 p3 mii
  lirq_sync_edge #(.WIDTH(4)) u_sync (
    .clk        (clk),
    .reset      (reset),
    .level_in   ({p3_mii_link, p1_mii_link, p2_analog_link, p1_analog_link}),
    .change_out (chg)
  );

  // ***************************************************
  // register file
  // ***************************************************
  logic [7:0] mask_r, mask_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic [7:0] pause_r, pause_nxt;
  logic [7:0] fiber_r, fiber_nxt;
  logic [7:0] ldo_r, ldo_nxt;
  logic [7:0] vid_r, vid_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       irq_n_r, irq_n_nxt;
  logic [7:0] evt;

  always_comb begin
    evt                  = 8'h00;
    evt[`LIRQ_FLG_P12]   = chg[0] | chg[1];
    evt[`LIRQ_FLG_P3]    = chg[3];
    evt[`LIRQ_FLG_P2]    = chg[1];
    evt[`LIRQ_FLG_P1]    = chg[0] | chg[2];
    mask_nxt  = mask_r;
    flags_nxt = flags_r;
    pause_nxt = pause_r;
    fiber_nxt = fiber_r;
    ldo_nxt   = ldo_r;
    vid_nxt   = vid_r;
    if (reg_wr) begin
      case (reg_addr)
        `LIRQ_OFF_MASK:  mask_nxt  = reg_wdata;
        `LIRQ_OFF_FLAGS: flags_nxt = (flags_r & ~(reg_wdata & `LIRQ_FLG_W1C_MASK))
                                     | (reg_wdata & ~`LIRQ_FLG_W1C_MASK);
        `LIRQ_OFF_PAUSE: pause_nxt = reg_wdata;
        `LIRQ_OFF_FIBER: fiber_nxt = reg_wdata & `LIRQ_FIBER_MASK;
        `LIRQ_OFF_REG:   ldo_nxt   = {1'b0, reg_wdata[`LIRQ_REG_DIS_BIT], 6'h00};
        `LIRQ_OFF_VID:   vid_nxt   = reg_wdata & `LIRQ_VID_MASK;
        default:         ;
      endcase
    end
    flags_nxt = flags_nxt | evt;  // set wins over clear
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      case (reg_addr)
        `LIRQ_OFF_MASK:  rdata_nxt = mask_r;
        `LIRQ_OFF_FLAGS: rdata_nxt = flags_r;
        `LIRQ_OFF_PAUSE: rdata_nxt = pause_r;
        `LIRQ_OFF_FIBER: rdata_nxt = fiber_r;
        `LIRQ_OFF_REG:   rdata_nxt = ldo_r;
        `LIRQ_OFF_VID:   rdata_nxt = vid_r;
        default:         rdata_nxt = 8'h00;
      endcase
    end
    irq_n_nxt = ~|(flags_r & mask_r);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_r  <= `LIRQ_RST_BYTE;
      flags_r <= `LIRQ_RST_BYTE;
      pause_r <= `LIRQ_RST_BYTE;
      fiber_r <= `LIRQ_RST_BYTE;
      ldo_r   <= `LIRQ_RST_BYTE;
      vid_r   <= `LIRQ_RST_BYTE;
      rdata_r <= 8'h00;
      irq_n_r <= 1'b1;
    end else begin
      mask_r  <= mask_nxt;
      flags_r <= flags_nxt;
      pause_r <= pause_nxt;
      fiber_r <= fiber_nxt;
      ldo_r   <= ldo_nxt;
      vid_r   <= vid_nxt;
      rdata_r <= rdata_nxt;
      irq_n_r <= irq_n_nxt;
    end
  end

  // ***************************************************
  // pause-off time limit
  // ***************************************************
  lirq_pause_st_t pst_r, pst_nxt;
  logic [31:0]    pcnt_r, pcnt_nxt;
  logic           preq_r, preq_nxt;
  logic           pause_en;

  assign pause_en = |pause_r;

  always_comb begin
    pst_nxt  = pst_r;
    pcnt_nxt = pcnt_r;
    preq_nxt = 1'b0;
    unique case (pst_r)
      LIRQ_P_IDLE: begin
        pcnt_nxt = 32'h0000_0000;
        if (pause_en && pause_active) begin
          pst_nxt = LIRQ_P_COUNT;
        end
      end
      LIRQ_P_COUNT: begin
        if (!pause_en || !pause_active) begin
          pst_nxt = LIRQ_P_IDLE;
        end else if (pcnt_r == 32'(PAUSE_LIMIT_CYC - 2)) begin
          pst_nxt  = LIRQ_P_REQ;
          preq_nxt = 1'b1;
        end else begin
          pcnt_nxt = pcnt_r + 32'h0000_0001;
        end
      end
      LIRQ_P_REQ: begin
        if (!pause_active || !pause_en) begin
          pst_nxt = LIRQ_P_IDLE;
        end else begin
          preq_nxt = 1'b1;
        end
      end
      default: pst_nxt = LIRQ_P_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pst_r  <= LIRQ_P_IDLE;
      pcnt_r <= 32'h0000_0000;
      preq_r <= 1'b0;
    end else begin
      pst_r  <= pst_nxt;
      pcnt_r <= pcnt_nxt;
      preq_r <= preq_nxt;
    end
  end

  // ***************************************************
  // vid insertion decision
  // ***************************************************
  logic ins_r, ins_nxt;
  logic ins_sel;

  always_comb begin
    ins_sel = 1'b0;
    unique case ({frm_src_port, frm_egress_port})
      4'h6:    ins_sel = vid_r[5];
      4'h7:    ins_sel = vid_r[4];
      4'h9:    ins_sel = vid_r[3];
      4'hb:    ins_sel = vid_r[2];
      4'hd:    ins_sel = vid_r[1];
      4'he:    ins_sel = vid_r[0];
      default: ins_sel = 1'b0;
    endcase
    ins_nxt = frm_valid & ((frm_untagged & ins_sel) | frm_tag_other);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ins_r <= 1'b0;
    end else begin
      ins_r <= ins_nxt;
    end
  end

  assign reg_rdata         = rdata_r;
  assign irq_out_pin_n     = irq_n_r;
  assign pause_off_req     = preq_r;
  assign fiber_thr_high    = fiber_r[7:6];
  assign regulator_disable = ldo_r[`LIRQ_REG_DIS_BIT];
  assign frm_insert_vid    = ins_r;

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  irq_on_mask_a: assert property (|(flags_r & mask_r) |=> !irq_out_pin_n) else $error("irq not asserted");
  irq_release_a: assert property (!(|(flags_r & mask_r)) |=> irq_out_pin_n) else $error("irq not released");
  flag_p12_set_a: assert property ((chg[0] || chg[1]) |=> flags_r[7]) else $error("flag 7 not set");
  flag_p3_set_a: assert property (chg[3] |=> flags_r[2]) else $error("flag 2 not set");
  flag_p2_set_a: assert property (chg[1] |=> flags_r[1] && flags_r[7]) else $error("flag 1 not set");
  flag_p1_set_a: assert property ((chg[0] || chg[2]) |=> flags_r[0]) else $error("flag 0 not set");
  flag_hold_a: assert property (flags_r[0] && !(reg_wr && reg_addr == `LIRQ_OFF_FLAGS && reg_wdata[0])
                                |=> flags_r[0]) else $error("flag 0 lost");
  flag_clear_a: assert property (reg_wr && reg_addr == `LIRQ_OFF_FLAGS && reg_wdata[1] && !chg[1]
                                 |=> !flags_r[1]) else $error("flag 1 not cleared");
  mask_gate_a: assert property (mask_r == 8'h00 |=> irq_out_pin_n) else $error("irq with mask zero");
  pause_off_a: assert property (!pause_en |=> !pause_off_req) else $error("pause request while disabled");
  ldo_follow_a: assert property (reg_wr && reg_addr == `LIRQ_OFF_REG
                                 |=> regulator_disable == $past(reg_wdata[6])) else $error("ldo mismatch");
  vid_ins_a: assert property (frm_valid && frm_untagged && frm_src_port == 2'd1 && frm_egress_port == 2'd2
                              |=> frm_insert_vid == ($past(vid_r[5]) || $past(frm_tag_other)))
                              else $error("vid insert mismatch");
  no_ins_a: assert property (frm_valid && !frm_tag_other && frm_src_port == 2'd3 && frm_egress_port == 2'd1
                             && !vid_r[1] |=> !frm_insert_vid) else $error("vid inserted while off");
endmodule : lirq_bank

// file: verif/lirq_bank_bench.sv
// self-checking testbench for the link interrupt register bank
`timescale 1ns/1ps
`include "lirq_regs.svh"
module lirq_bank_bench import lirq_pkg::*; ;
  logic       clk;
  logic       reset;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [3:0] links;
  logic       irq_out_pin_n;
  logic       pause_active;
  logic       pause_off_req;
  logic [1:0] fiber_thr_high;
  logic       regulator_disable;
  logic       frm_valid;
  logic [1:0] frm_src_port;
  logic [1:0] frm_egress_port;
  logic       frm_untagged;
  logic       frm_tag_other;
  logic       frm_insert_vid;
  int         bad_count;
  int         comparisons;
  int         cycles;
  logic [7:0] rv;
  int         n;
  lirq_bank #(.PAUSE_LIMIT_CYC(20)) lirq_bank_i (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .p1_analog_link(links[0]), .p2_analog_link(links[1]),
    .p1_mii_link(links[2]), .p3_mii_link(links[3]), .irq_out_pin_n(irq_out_pin_n),
    .pause_active(pause_active), .pause_off_req(pause_off_req), .fiber_thr_high(fiber_thr_high),
    .regulator_disable(regulator_disable), .frm_valid(frm_valid), .frm_src_port(frm_src_port),
    .frm_egress_port(frm_egress_port), .frm_untagged(frm_untagged), .frm_tag_other(frm_tag_other),
    .frm_insert_vid(frm_insert_vid));
  // ****************
  // access tasks
  // ****************
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk8($sformatf("reg %h", a), exp, reg_rdata);
  endtask : rd
  task automatic frame(input logic [1:0] s, input logic [1:0] e, input logic unt, input logic oth, input logic exp);
    @(posedge clk);
    frm_valid <= 1'b1;
    frm_src_port <= s;
    frm_egress_port <= e;
    frm_untagged <= unt;
    frm_tag_other <= oth;
    @(posedge clk);
    frm_valid <= 1'b0;
    #1;
    chk8($sformatf("insert %0d to %0d", s, e), {7'h00, exp}, {7'h00, frm_insert_vid});
  endtask : frame
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // ****************
  // clock, reset, timeout
  // ****************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    logic [7:0] flag_exp [4];
    logic [1:0] src_t [6];
    logic [1:0] egr_t [6];
    flag_exp = '{8'h81, 8'h82, 8'h01, 8'h04};
    src_t = '{2'd1, 2'd1, 2'd2, 2'd2, 2'd3, 2'd3};
    egr_t = '{2'd2, 2'd3, 2'd1, 2'd3, 2'd1, 2'd2};
    reset = 1'b1;
    {reg_addr, reg_wr, reg_wdata, reg_rd, links, pause_active} = 23'h00_0000;
    {frm_valid, frm_src_port, frm_egress_port, frm_untagged, frm_tag_other} = 7'h00;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    foreach (egr_t[i]) rd(8'hbb + 8'(i), 8'h00);
    rd(`LIRQ_OFF_VID, 8'h00);
    chk8("irq idle", 8'h01, {7'h00, irq_out_pin_n});
    wr(`LIRQ_OFF_FIBER, 8'hff);
    rd(`LIRQ_OFF_FIBER, 8'hc0);
    chk8("fiber", 8'h03, {6'h00, fiber_thr_high});
    wr(`LIRQ_OFF_FIBER, 8'h40);
    chk8("fiber p1", 8'h01, {6'h00, fiber_thr_high});
    wr(`LIRQ_OFF_REG, 8'hff);
    rd(`LIRQ_OFF_REG, 8'h40);
    chk8("regulator", 8'h01, {7'h00, regulator_disable});
    wr(8'hbe, 8'hff);
    rd(8'hbe, 8'h00);
    wr(`LIRQ_OFF_MASK, 8'h87);
    wr(`LIRQ_OFF_FLAGS, 8'h87);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      links[i] <= ~links[i];
      repeat (8) @(posedge clk);
      rd(`LIRQ_OFF_FLAGS, flag_exp[i]);
      chk8("irq set", 8'h00, {7'h00, irq_out_pin_n});
      wr(`LIRQ_OFF_FLAGS, flag_exp[i] & 8'h7f);
      repeat (3) @(posedge clk);
      chk8("irq held", {7'h00, ~flag_exp[i][7]}, {7'h00, irq_out_pin_n});
      wr(`LIRQ_OFF_FLAGS, 8'h80);
      repeat (3) @(posedge clk);
      rd(`LIRQ_OFF_FLAGS, 8'h00);
      chk8("irq free", 8'h01, {7'h00, irq_out_pin_n});
    end
    wr(`LIRQ_OFF_MASK, 8'h00);
    @(posedge clk);
    links[3] <= ~links[3];
    repeat (8) @(posedge clk);
    rd(`LIRQ_OFF_FLAGS, 8'h04);
    chk8("irq masked", 8'h01, {7'h00, irq_out_pin_n});
    @(posedge clk);
    pause_active <= 1'b1;
    repeat (40) @(posedge clk);
    chk8("pause off", 8'h00, {7'h00, pause_off_req});
    pause_active <= 1'b0;
    wr(`LIRQ_OFF_PAUSE, 8'h01);
    rd(`LIRQ_OFF_PAUSE, 8'h01);
    @(posedge clk);
    pause_active <= 1'b1;
    for (n = 1; n < 40; n++) begin
      @(posedge clk);
      #1;
      if (pause_off_req === 1'b1) break;
    end
    chk8("pause wait ok", 8'h01, {7'h00, n >= 19 && n <= 23});
    @(posedge clk);
    pause_active <= 1'b0;
    repeat (2) @(posedge clk);
    chk8("pause drop", 8'h00, {7'h00, pause_off_req});
    for (int b = 0; b < 6; b++) begin
      wr(`LIRQ_OFF_VID, 8'h01 << b);
      foreach (src_t[j]) frame(src_t[j], egr_t[j], 1'b1, 1'b0, (5 - j) == b);
    end
    wr(`LIRQ_OFF_VID, 8'hff);
    rd(`LIRQ_OFF_VID, 8'h3f);
    frame(2'd1, 2'd2, 1'b0, 1'b0, 1'b0);
    wr(`LIRQ_OFF_VID, 8'h00);
    frame(2'd1, 2'd2, 1'b1, 1'b0, 1'b0);
    frame(2'd3, 2'd1, 1'b1, 1'b1, 1'b1);
    report_and_stop();
  end
endmodule : lirq_bank_bench
